// file: hdl/css_top.sv
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
// Operation
// - frame error halts loading, init pulled low
// - after own frames, pass data downstream
// - start when memory full and count matches
// - next edge after match sets stage zero
// - taps drive done, I/O, set/reset release
// - three events placeable in any order
// - default: done, then I/O, then set/reset
// - later stages on config or user clock
// - config clock mode: stages 0-3 time events
// - user mode: stage one synchronises, shifts taps
// - sync option: done level feeds stage three
// - held-low done pin stalls start-up progress
// - chained devices match on same clock edge
// - set/reset holds flip-flops at initial state
// - last stage is the finish point, enables readback
module css_top #(
	parameter int FRAME_BITS = css_pkg::CSS_FRAME_BITS
) (
	input wire logic ref_clk, // 250 MHz system clock
	input wire logic rst_n, // async reset, active low
	input wire logic [7:0] reg_addr, // register byte address
	input wire logic [31:0] reg_wdata, // register write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [31:0] reg_rdata, // read data, cycle after strobe
	output logic irq, // level interrupt
	input wire logic config_clock, // configuration clock, sampled
	input wire logic user_startup_clock, // user start-up clock, sampled
	input wire logic cfg_data_in, // serial configuration data
	output logic daisy_out, // data to next chained device
	input wire logic init_in, // init status pin level
	output logic init_out, // init status pin drive value
	output logic init_oe_n, // init drive enable, low drives
	input wire logic done_in, // completion pin level (wire-AND)
	output logic done_out, // completion pin drive value
	output logic done_oe_n, // completion drive enable, low drives
	output logic io_active, // user I/O enabled
	output logic global_set_reset_net, // global set/reset, high holds
	output logic readback_en // finish point reached
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	typedef struct packed {
		logic config_clock_prev;
		logic uclk_prev;
		logic [31:0] ctrl;
		logic [css_pkg::CSS_FRM_W-1:0] frame_total;
		logic [css_pkg::CSS_CNT_W-1:0] length_count;
		logic [css_pkg::CSS_EV_W-1:0] status;
		logic [css_pkg::CSS_EV_W-1:0] mask;
		logic [css_pkg::CSS_FRM_W-1:0] frames_loaded;
		logic [css_pkg::CSS_CNT_W-1:0] clk_count;
		logic err_seen;
		logic mem_full;
		logic [css_pkg::CSS_STAGES-1:0] stage;
		logic daisy;
		logic init_oe_n;
		logic done_oe_n;
		logic io_on;
		logic gsr;
		logic rb_en;
		logic irq;
		logic [31:0] rdata;
	} css_state_t;

	css_state_t s;
	css_state_t next_s;
	css_frame_if fr ();

	logic config_clock_rise;
	logic uclk_rise;
	logic user_sel;
	logic sync_done;
	logic step;
	logic late_step;
	logic match;
	logic [2:0] done_idx;
	logic [2:0] io_idx;
	logic [2:0] gsr_idx;
	logic [css_pkg::CSS_EV_W-1:0] ev;
	logic [css_pkg::CSS_EV_W-1:0] clr;

	css_frame_check #(
		.FRAME_BITS(FRAME_BITS)
	) u_check (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.fr(fr.checker_end)
	);

	// map a two-bit tap choice to a stage; user mode moves every tap one stage later
	function automatic logic [2:0] tap_stage(input logic [1:0] sel, input logic user);
		tap_stage = {1'b0, sel} + {2'b00, user};
	endfunction

	// edge detect on the sampled clocks and decode of the option bits
	always_comb begin
		config_clock_rise = config_clock & ~s.config_clock_prev;
		uclk_rise = user_startup_clock & ~s.uclk_prev;
		user_sel = s.ctrl[css_pkg::CSS_CTRL_USER_CLK];
		sync_done = s.ctrl[css_pkg::CSS_CTRL_SYNC_DONE];
		step = user_sel ? uclk_rise : config_clock_rise;
		// with the sync option a low done level freezes the tail of the register
		late_step = step && (!sync_done || done_in);
		done_idx = tap_stage(s.ctrl[css_pkg::CSS_CTRL_DONE_TAP +: 2], user_sel);
		io_idx = tap_stage(s.ctrl[css_pkg::CSS_CTRL_IO_TAP +: 2], user_sel);
		gsr_idx = tap_stage(s.ctrl[css_pkg::CSS_CTRL_GSR_TAP +: 2], user_sel);
		// every chained device counts the same clocks, so all match on one edge
		match = s.mem_full && !s.err_seen && (s.clk_count == s.length_count);
	end

	// frame bits are fed only while loading is live; an error stops the feed for good
	assign fr.bit_valid = config_clock_rise && init_in && !s.mem_full && !s.err_seen;
	assign fr.bit_data = cfg_data_in;

	// write-one-to-clear decode for the status register
	always_comb begin
		clr = '0;
		if (reg_wr && reg_addr == css_pkg::CSS_STATUS_OFF) begin
			clr = reg_wdata[css_pkg::CSS_EV_W-1:0];
		end
	end

	// next state of the whole block
	always_comb begin
		next_s = s;
		next_s.config_clock_prev = config_clock;
		next_s.uclk_prev = user_startup_clock;

		// frame bookkeeping
		if (fr.frame_err) begin
			next_s.err_seen = 1'b1;
		end else if (fr.frame_done) begin
			next_s.frames_loaded = s.frames_loaded + 16'h0001;
			if (s.frames_loaded + 16'h0001 >= s.frame_total) begin
				next_s.mem_full = 1'b1;
			end
		end

		// once full, surplus data goes straight down the chain
		if (s.mem_full && config_clock_rise) begin
			next_s.daisy = cfg_data_in;
		end

		// clocks counted from the rise of init; a low init restarts the count
		if (!init_in) begin
			next_s.clk_count = '0;
		end else if (config_clock_rise && !s.stage[0]) begin
			next_s.clk_count = s.clk_count + 24'h00_0001;
		end

		// first stage on the config clock edge after the match
		if (match && config_clock_rise) begin
			next_s.stage[0] = 1'b1;
		end
		// in user mode stage one is the crossing point between the two clocks
		if (step) begin
			next_s.stage[1] = s.stage[0];
			next_s.stage[2] = s.stage[1];
		end
		// stage three sees the wire-ANDed done level when the sync option is on
		if (late_step) begin
			next_s.stage[3] = s.stage[2] && (!sync_done || done_in);
			next_s.stage[4] = s.stage[3];
		end

		// event taps; until stage zero every tap reads low
		next_s.done_oe_n = next_s.stage[done_idx];
		next_s.io_on = next_s.stage[io_idx];
		next_s.gsr = !next_s.stage[gsr_idx];
		next_s.rb_en = next_s.stage[css_pkg::CSS_STAGES-1];
		next_s.init_oe_n = !next_s.err_seen;

		// register writes
		if (reg_wr) begin
			unique case (reg_addr)
				css_pkg::CSS_CTRL_OFF: next_s.ctrl = reg_wdata;
				css_pkg::CSS_FRAMES_OFF: next_s.frame_total = reg_wdata[css_pkg::CSS_FRM_W-1:0];
				css_pkg::CSS_LENGTH_OFF: next_s.length_count = reg_wdata[css_pkg::CSS_CNT_W-1:0];
				css_pkg::CSS_MASK_OFF: next_s.mask = reg_wdata[css_pkg::CSS_EV_W-1:0];
				default: ;
			endcase
		end

		// sticky events; a new event beats a clear in the same cycle
		ev = '0;
		ev[css_pkg::CSS_EV_FRAME_ERR] = fr.frame_err;
		ev[css_pkg::CSS_EV_STARTED] = next_s.stage[0] && !s.stage[0];
		ev[css_pkg::CSS_EV_FINISHED] = next_s.rb_en && !s.rb_en;
		ev[css_pkg::CSS_EV_MEM_FULL] = next_s.mem_full && !s.mem_full;
		next_s.status = (s.status & ~clr) | ev;
		next_s.irq = |(next_s.status & next_s.mask);

		// read data stand for one cycle only; unmapped reads return zero
		next_s.rdata = 32'h0000_0000;
		if (reg_rd) begin
			unique case (reg_addr)
				css_pkg::CSS_CTRL_OFF: next_s.rdata = s.ctrl;
				css_pkg::CSS_FRAMES_OFF: next_s.rdata = 32'(s.frame_total);
				css_pkg::CSS_LENGTH_OFF: next_s.rdata = 32'(s.length_count);
				css_pkg::CSS_STATUS_OFF: next_s.rdata = 32'(s.status);
				css_pkg::CSS_MASK_OFF: next_s.rdata = 32'(s.mask);
				css_pkg::CSS_STATE_OFF: next_s.rdata = {s.clk_count, s.err_seen, s.mem_full,
					1'b0, s.stage};
				default: next_s.rdata = 32'h0000_0000;
			endcase
		end
	end

	// the single state register; reset drives done low, leaves init released, I/O off and set/reset on
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.ctrl <= css_pkg::CSS_CTRL_RST;
			s.frame_total <= css_pkg::CSS_FRAMES_RST;
			s.length_count <= css_pkg::CSS_LENGTH_RST;
			s.mask <= css_pkg::CSS_MASK_RST;
			s.daisy <= 1'b1;
			s.init_oe_n <= 1'b1;
			s.gsr <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// open-drain pins only ever pull low, so the drive value is a constant
	assign init_out = 1'b0;
	assign done_out = 1'b0;
	assign reg_rdata = s.rdata;
	assign irq = s.irq;
	assign daisy_out = s.daisy;
	assign init_oe_n = s.init_oe_n;
	assign done_oe_n = s.done_oe_n;
	assign io_active = s.io_on;
	assign global_set_reset_net = s.gsr;
	assign readback_en = s.rb_en;

	// a frame error pulls init low on the next cycle and keeps it there
	err_init_low_a: assert property (fr.frame_err |=> !init_oe_n [*3])
		else $error("init not held low after frame error");

	// surplus data follow the input on every config edge once full
	daisy_pass_a: assert property ((s.mem_full && config_clock_rise) |=> daisy_out == $past(cfg_data_in))
		else $error("daisy output did not follow input data");

	// stage zero rises only on a config edge where count and length agree
	start_on_match_a: assert property ($rose(s.stage[0]) |-> $past(match && config_clock_rise))
		else $error("start-up began without a length count match");

	// shifting keeps order: a stage never sets before its predecessor
	stage_order_a: assert property ($rose(s.stage[2]) |-> $past(s.stage[1] && step))
		else $error("start-up stage set out of order");

	// default taps in config clock mode: done, then I/O, then set/reset
	default_order_a: assert property ((s.ctrl == css_pkg::CSS_CTRL_RST && $rose(io_active))
		|-> done_oe_n && global_set_reset_net)
		else $error("default release order broken");

	// in user mode stage one moves only on a user clock edge
	user_sync_a: assert property ((user_sel && $changed(s.stage[1])) |-> $past(uclk_rise))
		else $error("stage one moved without a user clock edge");

	// with the stall option a low done pin freezes stage three
	stall_hold_a: assert property ((sync_done && !done_in && !s.stage[3]) |=> !s.stage[3])
		else $error("start-up advanced while done held low");

	// before stage zero all three events stay in their configuring state
	pre_start_hold_a: assert property (!s.stage[0] |-> (!done_oe_n && !io_active
		&& global_set_reset_net))
		else $error("event released before start-up began");

	// readback permitted only once the last stage is reached
	readback_gate_a: assert property (readback_en |-> s.stage[css_pkg::CSS_STAGES-1])
		else $error("readback enabled before finish point");

	// interrupt level follows unmasked sticky status
	irq_level_a: assert property (irq == |(s.status & s.mask))
		else $error("interrupt does not match masked status");

	// init stays pulled low once it has been pulled
	init_sticky_a: assert property (!init_oe_n |=> !init_oe_n)
		else $error("init released after a frame error");

	// an error stops loading before memory fills, so start-up never begins
	load_halt_a: assert property (s.err_seen |-> (!s.mem_full && !s.stage[0]))
		else $error("loading went on after a frame error");

	// no frame bit reaches the checker after an error or while init is low
	feed_gate_a: assert property ((s.err_seen || !init_in) |-> !fr.bit_valid)
		else $error("frame bit fed while loading was halted");

	// the daisy output idles high until the own frames are in
	daisy_idle_a: assert property (!s.mem_full |-> daisy_out)
		else $error("daisy output moved before memory was full");

	// a low init restarts the clock count on the next cycle
	count_clear_a: assert property (!init_in |=> (s.clk_count == '0))
		else $error("clock count not cleared while init low");

	// each counted config edge adds exactly one
	count_step_a: assert property ((init_in && config_clock_rise && !s.stage[0])
		|=> (s.clk_count == $past(s.clk_count) + 24'h00_0001))
		else $error("clock count did not advance by one");

	// the match edge sets stage zero, the same edge on every chained device
	match_start_a: assert property ((match && config_clock_rise) |=> s.stage[0])
		else $error("length count match did not start the sequence");

	// a set stage is never dropped before reset
	stages_keep_a: assert property ((s.stage & $past(s.stage)) == $past(s.stage))
		else $error("start-up stage dropped");

	// software sees the start of the sequence in the same cycle
	started_flag_a: assert property ($rose(s.stage[0])
		|-> s.status[css_pkg::CSS_EV_STARTED])
		else $error("start-up event not flagged");

	// taps follow their stages while the option bits stand still
	tap_follow_a: assert property ($stable(s.ctrl) |->
		(done_oe_n == s.stage[done_idx] && io_active == s.stage[io_idx]
		&& global_set_reset_net == !s.stage[gsr_idx]))
		else $error("event output does not follow its tap");

	// in user mode nothing is released before stage one has synchronised
	user_bridge_a: assert property ((user_sel && $stable(s.ctrl)) |-> (s.stage[1]
		|| (!done_oe_n && !io_active && global_set_reset_net)))
		else $error("event released before the user clock bridge");

	// with the sync option stage three only sets while done reads high
	sync_input_a: assert property (($past(sync_done) && $rose(s.stage[3]))
		|-> $past(done_in))
		else $error("stage three set while done was low");

	// the finish point, once reached, is kept until reset
	finish_keep_a: assert property (readback_en |=> readback_en)
		else $error("finish point lost");

	// a fresh event is never lost to a clear in the same cycle
	event_set_a: assert property ((ev != '0) |=> ((s.status & $past(ev)) == $past(ev)))
		else $error("status event lost");

	// read data are zero outside the cycle after a read strobe
	rdata_idle_a: assert property (!reg_rd |=> (reg_rdata == 32'h0000_0000))
		else $error("read data outside the read cycle");
endmodule // css_top

// file: hdl/css_pkg.sv
package css_pkg;
	// register byte offsets
	localparam logic [7:0] CSS_CTRL_OFF = 8'h00;
	localparam logic [7:0] CSS_FRAMES_OFF = 8'h04;
	localparam logic [7:0] CSS_LENGTH_OFF = 8'h08;
	localparam logic [7:0] CSS_STATUS_OFF = 8'h0c;
	localparam logic [7:0] CSS_MASK_OFF = 8'h10;
	localparam logic [7:0] CSS_STATE_OFF = 8'h14;

	// control field positions
	localparam int CSS_CTRL_USER_CLK = 0;
	localparam int CSS_CTRL_SYNC_DONE = 1;
	localparam int CSS_CTRL_DONE_TAP = 4;
	localparam int CSS_CTRL_IO_TAP = 6;
	localparam int CSS_CTRL_GSR_TAP = 8;

	// status and mask bit positions
	localparam int CSS_EV_FRAME_ERR = 0;
	localparam int CSS_EV_STARTED = 1;
	localparam int CSS_EV_FINISHED = 2;
	localparam int CSS_EV_MEM_FULL = 3;
	localparam int CSS_EV_W = 4;

	// widths and sizes
	localparam int CSS_CNT_W = 24;
	localparam int CSS_FRM_W = 16;
	localparam int CSS_STAGES = 5;
	localparam int CSS_FRAME_BITS = 16;
	localparam int CSS_ERR_FIELD_W = 4;

	// values after reset: done first, I/O one step later, set/reset last
	localparam logic [31:0] CSS_CTRL_RST = 32'h0000_0390;
	localparam logic [CSS_FRM_W-1:0] CSS_FRAMES_RST = 16'h0001;
	localparam logic [CSS_CNT_W-1:0] CSS_LENGTH_RST = 24'h00_0020;
	localparam logic [CSS_EV_W-1:0] CSS_MASK_RST = 4'h0;
	localparam logic [CSS_ERR_FIELD_W-1:0] CSS_FRAME_CHECK = 4'h6;
endpackage

// file: hdl/css_frame_if.sv
`timescale 1ns/1ns
// carries serial configuration bits to the frame checker and its verdicts back
interface css_frame_if;
	logic bit_valid;
	logic bit_data;
	logic frame_done;
	logic frame_err;
	modport checker_end (input bit_valid, input bit_data, output frame_done, output frame_err);
	modport seq_end (output bit_valid, output bit_data, input frame_done, input frame_err);
endinterface

// file: hdl/css_frame_check.sv
`timescale 1ns/1ns
module css_frame_check #(
	parameter int FRAME_BITS = css_pkg::CSS_FRAME_BITS
) (
	input wire logic ref_clk, // system clock
	input wire logic rst_n, // async reset, active low
	css_frame_if.checker_end fr // bit stream in, verdicts out
);
	typedef struct packed {
		logic [15:0] bit_cnt;
		logic [css_pkg::CSS_ERR_FIELD_W-1:0] field;
		logic done;
		logic err;
	} css_chk_t;

	localparam logic [15:0] LAST_BIT = 16'(FRAME_BITS + css_pkg::CSS_ERR_FIELD_W - 1);

	css_chk_t s;
	css_chk_t next_s;
	logic [css_pkg::CSS_ERR_FIELD_W-1:0] next_field;

	// each frame is data bits then the error field; verdict pulses after its last bit
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		next_s.err = 1'b0;
		next_field = {s.field[css_pkg::CSS_ERR_FIELD_W-2:0], fr.bit_data};
		if (fr.bit_valid) begin
			next_s.field = next_field;
			if (s.bit_cnt == LAST_BIT) begin
				next_s.bit_cnt = 16'h0000;
				next_s.done = 1'b1;
				next_s.err = (next_field != css_pkg::CSS_FRAME_CHECK);
			end else begin
				next_s.bit_cnt = s.bit_cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign fr.frame_done = s.done;
	assign fr.frame_err = s.err;

	// a verdict only ever follows the final bit of a frame
	frame_verdict_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s.done |-> $past(fr.bit_valid && s.bit_cnt == LAST_BIT))
		else $error("frame verdict without a completed frame");
endmodule // css_frame_check

// file: tb/css_cfg_source.sv
`timescale 1ns/1ns
// configuration data source: the config clock stands low between requested pulses
module css_cfg_source (
	input wire logic ref_clk, // system clock
	output logic config_clock, // configuration clock
	output logic cfg_data_in, // serial configuration data
	output logic done_rel_n // low holds the completion wire low
);
	// idle levels before the first request
	initial begin
		config_clock = 1'b0;
		cfg_data_in = 1'b0;
		done_rel_n = 1'b1;
	end
	// one bit per pulse; the bench asks for 20 per run, only the first 13 in user clock mode
	task automatic pulse(input logic b);
		@(posedge ref_clk);
		cfg_data_in <= b;
		repeat (2) @(posedge ref_clk);
		config_clock <= 1'b1;
		repeat (4) @(posedge ref_clk);
		config_clock <= 1'b0;
		cfg_data_in <= ~b; // released line has no pull, so show the inverse
		repeat (3) @(posedge ref_clk);
	endtask
	// outside party holding the wire-ANDed completion pin low
	task automatic hold(input logic on);
		@(posedge ref_clk);
		done_rel_n <= !on;
	endtask
endmodule // css_cfg_source

// file: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
	localparam logic [7:0] st_off = css_pkg::CSS_STATUS_OFF;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic user_startup_clock = 1'b0;
	logic [31:0] reg_rdata;
	logic irq, config_clock, cfg_data_in, daisy_out, init_in, init_out, init_oe_n;
	logic done_in, done_out, done_oe_n, io_active, global_set_reset_net, readback_en, done_rel_n;
	logic [31:0] rnd = 32'h44e36a2b;
	logic [4:0] stg;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #2 ref_clk = ~ref_clk;
	// open-drain wires: pull-up on init, wire-AND on done
	assign init_in = init_oe_n ? 1'b1 : init_out;
	assign done_in = (done_oe_n ? 1'b1 : done_out) & done_rel_n;
	css_top #(.FRAME_BITS(4)) i_css_top (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.config_clock(config_clock), .user_startup_clock(user_startup_clock),
		.cfg_data_in(cfg_data_in), .daisy_out(daisy_out), .init_in(init_in), .init_out(init_out),
		.init_oe_n(init_oe_n), .done_in(done_in), .done_out(done_out), .done_oe_n(done_oe_n),
		.io_active(io_active), .global_set_reset_net(global_set_reset_net),
		.readback_en(readback_en));
	css_cfg_source i_css_cfg_source (.ref_clk(ref_clk), .config_clock(config_clock),
		.cfg_data_in(cfg_data_in), .done_rel_n(done_rel_n));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	task automatic hard_reset();
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
	endtask
	task automatic upulse();
		@(posedge ref_clk);
		user_startup_clock <= 1'b1;
		repeat (3) @(posedge ref_clk);
		user_startup_clock <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask
	// model of the start-up register; with the sync option stages three and four wait for the done wire
	task automatic step(input logic sync, input logic dl);
		logic [4:0] n;
		n = {stg[3:0], stg[0]};
		if (sync && !dl) n[4:3] = stg[4:3];
		stg = n;
	endtask
	// one load and start-up; the match edge is LENGTH+1 with one 8-bit frame
	task automatic run(input logic [31:0] c, input logic bad, input logic stall);
		logic [3:0] fld, msk;
		logic [31:0] st;
		logic b, dl, hld, dex;
		int k, u;
		hard_reset();
		stg = 5'h00;
		dex = 1'b1;
		hld = stall;
		u = c[0];
		rnd = lfsr(rnd);
		msk = rnd[3:0];
		fld = 4'h6 ^ (bad ? (rnd[7:4] | 4'h1) : 4'h0);
		wr(css_pkg::CSS_CTRL_OFF, c);
		wr(css_pkg::CSS_LENGTH_OFF, 32'h0000_000c);
		wr(css_pkg::CSS_MASK_OFF, {28'h000_0000, msk});
		i_css_cfg_source.hold(stall);
		for (k = 1; k <= 20; k++) begin
			rnd = lfsr(rnd);
			b = (k > 4 && k <= 8) ? fld[8 - k] : rnd[0];
			if (k == 19 && stall) begin
				hld = 1'b0;
				i_css_cfg_source.hold(1'b0);
			end
			dl = stg[c[5:4] + u] & !hld;
			if (u == 1 && k > 13) upulse();
			else begin
				i_css_cfg_source.pulse(b);
				dex = (k > 8 && !bad) ? b : 1'b1;
			end
			if (u == 0 || k > 13) step(c[1], dl);
			if (k == 13 && !bad) stg[0] = 1'b1;
			#1;
			chk(done_oe_n, stg[c[5:4] + u]);
			chk(io_active, stg[c[7:6] + u]);
			chk(global_set_reset_net, !stg[c[9:8] + u]);
			chk(readback_en, stg[4]);
			chk(daisy_out, dex);
			chk(init_oe_n, !(bad && k >= 8));
		end
		st = {(bad ? 24'h00_0000 : 24'h00_000d), bad, !bad, 1'b0, stg};
		rdchk(css_pkg::CSS_STATE_OFF, st);
		st = {28'h000_0000, !bad, stg[4], stg[0], bad};
		rdchk(st_off, st);
		chk(irq, |(st[3:0] & msk));
		wr(st_off, st);
		rdchk(st_off, 32'h0000_0000);
		chk(irq, 1'b0);
	endtask
	// cut a hang short
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			close_out();
		end
	end
	// main sequence
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		#1;
		chk({done_oe_n, io_active, global_set_reset_net, readback_en}, 4'h2);
		chk({init_out, done_out}, 32'h0000_0000);
		rdchk(css_pkg::CSS_CTRL_OFF, css_pkg::CSS_CTRL_RST);
		rdchk(css_pkg::CSS_FRAMES_OFF, 32'h0000_0001);
		rdchk(css_pkg::CSS_LENGTH_OFF, 32'h0000_0020);
		rdchk(css_pkg::CSS_MASK_OFF, 32'h0000_0000);
		wr(8'h18, 32'hffff_ffff);
		rdchk(8'h18, 32'h0000_0000);
		wr(css_pkg::CSS_STATE_OFF, 32'hffff_ffff);
		rdchk(css_pkg::CSS_STATE_OFF, 32'h0000_0000);
		wr(css_pkg::CSS_FRAMES_OFF, 32'h0000_0003);
		rdchk(css_pkg::CSS_FRAMES_OFF, 32'h0000_0003);
		run(css_pkg::CSS_CTRL_RST, 1'b0, 1'b0);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			run({22'h00_0000, rnd[7:2], 3'h0, i[0]}, 1'b0, 1'b0);
		end
		run(css_pkg::CSS_CTRL_RST | 32'h0000_0002, 1'b0, 1'b1);
		run(css_pkg::CSS_CTRL_RST, 1'b1, 1'b0);
		close_out();
	end
endmodule // testbench
